// ### common/rcl_map.svh
/*
 * Register map, field positions, reset values and window constants of the
 * reference clock lock and rate meter block.
 * Assumes it is included by its bare name, once per compile unit.
 */
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH

// register subaddresses seen by the serial register port
`define RCL_ADDR_MODE_CTRL 8'h00
`define RCL_ADDR_ACQ_CTRL 8'h01
`define RCL_ADDR_MISC_STATUS 8'h02
`define RCL_ADDR_RESULT_HIGH 8'h03
`define RCL_ADDR_RESULT_MID 8'h04
`define RCL_ADDR_RESULT_LOW 8'h05

`define RCL_REG_W 8
`define RCL_REG_RESET 8'h00
`define RCL_RD_UNMAPPED 8'h00

// reference_mode_control fields
`define RCL_MODE_LOCK_REF_BIT 0
`define RCL_MODE_MEAS_BIT 1
`define RCL_MODE_RATIO_LSB 2
`define RCL_MODE_RATIO_MSB 5
`define RCL_MODE_RANGE_LSB 6
`define RCL_MODE_RANGE_MSB 7

// acquisition_control fields
`define RCL_ACQ_MEAS_RESTART_BIT 3
`define RCL_ACQ_RESTART_BIT 5

// misc status fields
`define RCL_MISC_DONE_BIT 2

// measurement result and gate window
`define RCL_RESULT_W 23
`define RCL_RESULT_HIGH_MSB 22
`define RCL_RESULT_HIGH_LSB 16
`define RCL_RESULT_MID_MSB 15
`define RCL_RESULT_MID_LSB 8
`define RCL_RESULT_LOW_MSB 7
`define RCL_RESULT_LOW_LSB 0
`define RCL_RANGE_W 2
`define RCL_RATIO_W 4
`define RCL_REF_CNT_W 18
`define RCL_WIN_BASE_LOG2 5'h0E
`define RCL_REF_CNT_ONE 18'h00001
`define RCL_RESULT_ONE 23'h000001

`endif

// ### common/rcl_pkg.sv
/*
 * Types shared by the reference clock lock and rate meter modules.
 * Assumes rcl_map.svh is on the include path.
 */
`include "rcl_map.svh"

package rcl_pkg;

    typedef enum logic [0:0] {
        RCL_MEAS_IDLE,
        RCL_MEAS_RUN
    } rcl_meas_e;

    typedef logic [`RCL_REG_W-1:0] rcl_reg_t;
    typedef logic [`RCL_RESULT_W-1:0] rcl_result_t;
    typedef logic [`RCL_RANGE_W-1:0] rcl_range_t;
    typedef logic [`RCL_RATIO_W-1:0] rcl_ratio_t;

    typedef struct packed {
        rcl_meas_e state;
        logic [`RCL_REF_CNT_W-1:0] ref_cnt;
        rcl_result_t rate_cnt;
        rcl_result_t result;
        logic done;
    } rcl_meter_s;

    typedef struct packed {
        rcl_reg_t mode_ctrl;
        rcl_reg_t acq_ctrl;
        rcl_reg_t rd_data;
        logic ref_prev;
        logic ref_rise;
        logic lock_lost_prev;
        logic acq_restart;
        logic meas_start;
    } rcl_top_s;

endpackage

// ### common/rcl_meas_if.sv
/*
 * Carrier between the control block and the rate meter.
 * Assumes both ends share one clock; pulses last one cycle.
 */
`timescale 1ns/1ps

interface rcl_meas_if;
    import rcl_pkg::*;

    logic start;
    logic enable;
    rcl_range_t range;
    logic ref_rise;
    logic rate_tick;
    logic done;
    rcl_result_t result;

    modport ctl (
        output start,
        output enable,
        output range,
        output ref_rise,
        output rate_tick,
        input done,
        input result
    );

    modport meter (
        input start,
        input enable,
        input range,
        input ref_rise,
        input rate_tick,
        output done,
        output result
    );
endinterface

// ### rtl/rcl_rate_meter.sv
/*
 * Fine rate meter: counts recovered-rate ticks over a gate of
 * 2^(14+range) reference rising edges, then latches the count.
 * Assumes start, ref_rise and rate_tick are single-cycle pulses on clk.
 */
`timescale 1ns/1ps
`include "rcl_map.svh"

module rcl_rate_meter (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control side
    rcl_meas_if.meter mif
);
    import rcl_pkg::*;

    rcl_meter_s state_ff;
    rcl_meter_s nxt_state;
    logic [`RCL_REF_CNT_W-1:0] win_last;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // gate length tracks the range field so the result scales by 2^(14+range)
        win_last = (`RCL_REF_CNT_ONE << (`RCL_WIN_BASE_LOG2 + 5'(mif.range))) - `RCL_REF_CNT_ONE;
        nxt_state = state_ff;
        if (mif.start) begin
            nxt_state.done = 1'b0;
            nxt_state.ref_cnt = '0;
            nxt_state.rate_cnt = '0;
            nxt_state.state = mif.enable ? RCL_MEAS_RUN : RCL_MEAS_IDLE;
        end else begin
            case (state_ff.state)
                RCL_MEAS_IDLE: begin
                    nxt_state.state = RCL_MEAS_IDLE;
                end
                RCL_MEAS_RUN: begin
                    // saturate rather than wrap so an overrange shows as all ones
                    if (mif.rate_tick && (state_ff.rate_cnt != '1)) begin
                        nxt_state.rate_cnt = state_ff.rate_cnt + `RCL_RESULT_ONE;
                    end
                    if (!mif.enable) begin
                        nxt_state.state = RCL_MEAS_IDLE;
                    end else if (mif.ref_rise) begin
                        if (state_ff.ref_cnt == win_last) begin
                            // a whole count of ticks; besides the reference's own error, the gate start is not aligned to a reference edge, so one count of slack remains
                            nxt_state.result = nxt_state.rate_cnt;
                            nxt_state.done = 1'b1;
                            nxt_state.state = RCL_MEAS_IDLE;
                        end else begin
                            nxt_state.ref_cnt = state_ff.ref_cnt + `RCL_REF_CNT_ONE;
                        end
                    end
                end
                default: begin
                    nxt_state.state = RCL_MEAS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= '{state: RCL_MEAS_IDLE, ref_cnt: '0, rate_cnt: '0, result: '0, done: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign mif.done = state_ff.done;
    assign mif.result = state_ff.result;
endmodule

// ### rtl/rcl_ref_clock_in_ctrl.sv
/*
 * Reference clock control: lock-to-reference configuration, acquisition
 * restart generation and the fine data-rate measurement registers.
 * Assumes a register port from the serial slave (one write strobe, address,
 * write data, registered read data) and inputs synchronous to clk; the
 * reference is sampled, so it must be well below half the clk rate.
 */
`timescale 1ns/1ps
`include "rcl_map.svh"

module rcl_ref_clock_in_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port from the serial slave
    input wire logic reg_wr_en,
    input wire logic [`RCL_REG_W-1:0] reg_addr,
    input wire rcl_pkg::rcl_reg_t reg_wr_data,
    output logic [`RCL_REG_W-1:0] reg_rd_data,
    // reference and recovered-rate inputs
    input wire logic ref_clock_in,
    input wire logic rate_tick,
    input wire logic lock_lost,
    // to the recovery loops
    output logic lock_to_reference_mode,
    output rcl_pkg::rcl_range_t ref_range,
    output rcl_pkg::rcl_ratio_t ref_ratio_field,
    output logic acq_restart
);
    import rcl_pkg::*;

    rcl_top_s state_ff;
    rcl_top_s nxt_state;
    rcl_reg_t mode_wr;
    rcl_reg_t acq_wr;
    logic wr_mode;
    logic wr_acq;
    rcl_result_t rate_result;
    logic meas_done;
    // stored and incoming values of the bits whose edges start things
    logic lock_en_old;
    logic lock_en_new;
    logic restart_bit_old;
    logic restart_bit_new;
    logic meas_bit_old;
    logic meas_bit_new;
    logic lock_lost_rise;
    // one term per acquisition restart source, plus the measurement start
    logic restart_by_bit;
    logic restart_by_enable;
    logic restart_by_lock;
    logic meas_restart;
    // read-back bytes of the rate result
    rcl_reg_t result_high_byte;
    rcl_reg_t result_mid_byte;
    rcl_reg_t result_low_byte;

    rcl_meas_if mif ();

    ////////////////////////////////////////////////////////////////////////////
    rcl_rate_meter u_meter (
        .clk(clk),
        .reset(reset),
        .mif(mif.meter)
    );

    assign mif.start = state_ff.meas_start;
    assign mif.enable = state_ff.mode_ctrl[`RCL_MODE_MEAS_BIT];
    assign mif.range = state_ff.mode_ctrl[`RCL_MODE_RANGE_MSB:`RCL_MODE_RANGE_LSB];
    assign mif.ref_rise = state_ff.ref_rise;
    assign mif.rate_tick = rate_tick;
    assign rate_result = mif.result;
    assign meas_done = mif.done;

    ////////////////////////////////////////////////////////////////////////////
    assign wr_mode = reg_wr_en && (reg_addr == `RCL_ADDR_MODE_CTRL);
    assign wr_acq = reg_wr_en && (reg_addr == `RCL_ADDR_ACQ_CTRL);

    // edges are judged between the stored byte and the byte being written,
    // so a host that rewrites the same value starts nothing
    assign lock_en_old = state_ff.mode_ctrl[`RCL_MODE_LOCK_REF_BIT];
    assign lock_en_new = reg_wr_data[`RCL_MODE_LOCK_REF_BIT];
    assign restart_bit_old = state_ff.acq_ctrl[`RCL_ACQ_RESTART_BIT];
    assign restart_bit_new = reg_wr_data[`RCL_ACQ_RESTART_BIT];
    assign meas_bit_old = state_ff.acq_ctrl[`RCL_ACQ_MEAS_RESTART_BIT];
    assign meas_bit_new = reg_wr_data[`RCL_ACQ_MEAS_RESTART_BIT];
    assign lock_lost_rise = lock_lost && !state_ff.lock_lost_prev;

    assign restart_by_bit = wr_acq && restart_bit_old && !restart_bit_new;
    assign restart_by_enable = wr_mode && !lock_en_old && lock_en_new;
    // only in reference mode; otherwise the free-running loops reacquire by themselves
    assign restart_by_lock = lock_en_old && lock_lost_rise;
    assign meas_restart = wr_acq && meas_bit_old && !meas_bit_new;

    // the high byte carries seven result bits; its top bit reads zero
    assign result_high_byte = {1'b0, rate_result[`RCL_RESULT_HIGH_MSB:`RCL_RESULT_HIGH_LSB]};
    assign result_mid_byte = rate_result[`RCL_RESULT_MID_MSB:`RCL_RESULT_MID_LSB];
    assign result_low_byte = rate_result[`RCL_RESULT_LOW_MSB:`RCL_RESULT_LOW_LSB];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        mode_wr = wr_mode ? reg_wr_data : state_ff.mode_ctrl;
        acq_wr = wr_acq ? reg_wr_data : state_ff.acq_ctrl;
        nxt_state = state_ff;
        nxt_state.mode_ctrl = mode_wr;
        nxt_state.acq_ctrl = acq_wr;

        // sampled reference edge feeds the gate counter
        nxt_state.ref_prev = ref_clock_in;
        nxt_state.ref_rise = ref_clock_in && !state_ff.ref_prev;
        nxt_state.lock_lost_prev = lock_lost;

        // the measure enable is deliberately not a source so measuring leaves acquisition alone;
        // coinciding sources merge into one pulse
        nxt_state.acq_restart = restart_by_bit || restart_by_enable || restart_by_lock;
        nxt_state.meas_start = meas_restart;

        case (reg_addr)
            `RCL_ADDR_MODE_CTRL: begin
                nxt_state.rd_data = state_ff.mode_ctrl;
            end
            `RCL_ADDR_ACQ_CTRL: begin
                nxt_state.rd_data = state_ff.acq_ctrl;
            end
            `RCL_ADDR_MISC_STATUS: begin
                nxt_state.rd_data = `RCL_REG_RESET;
                nxt_state.rd_data[`RCL_MISC_DONE_BIT] = meas_done;
            end
            `RCL_ADDR_RESULT_HIGH: begin
                nxt_state.rd_data = result_high_byte;
            end
            `RCL_ADDR_RESULT_MID: begin
                nxt_state.rd_data = result_mid_byte;
            end
            `RCL_ADDR_RESULT_LOW: begin
                nxt_state.rd_data = result_low_byte;
            end
            default: begin
                nxt_state.rd_data = `RCL_RD_UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= '{
                mode_ctrl: `RCL_REG_RESET,
                acq_ctrl: `RCL_REG_RESET,
                rd_data: `RCL_REG_RESET,
                ref_prev: 1'b0,
                ref_rise: 1'b0,
                lock_lost_prev: 1'b0,
                acq_restart: 1'b0,
                meas_start: 1'b0
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs are flop bits of the state; the analog loop applies 2^ratio / 2^range
    assign reg_rd_data = state_ff.rd_data;
    assign lock_to_reference_mode = state_ff.mode_ctrl[`RCL_MODE_LOCK_REF_BIT];
    assign ref_range = state_ff.mode_ctrl[`RCL_MODE_RANGE_MSB:`RCL_MODE_RANGE_LSB];
    assign ref_ratio_field = state_ff.mode_ctrl[`RCL_MODE_RATIO_MSB:`RCL_MODE_RATIO_LSB];
    assign acq_restart = state_ff.acq_restart;
endmodule

// ### tb/rcl_far_side.sv
/* far side model: free-running reference oscillator and recovered-rate ticks.
   assumes clk at 200 MHz; reference is clk/4, ticks come at half its rate. */
`timescale 1ns/1ps
module rcl_far_side (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // towards the block
    output logic ref_clock_in,
    output logic rate_tick
);
    logic [2:0] cnt_ff;
    // an oscillator never stops, so reset does not hold it
    always_ff @(posedge clk) begin
        cnt_ff <= (cnt_ff === 3'hX) ? 3'h0 : cnt_ff + 3'h1;
    end
    assign ref_clock_in = cnt_ff[1];
    assign rate_tick = (cnt_ff == 3'h1);
endmodule

// ### tb/rcl_ref_clock_in_checker.sv
/* port assertions of the reference clock control block.
   assumes rcl_pkg and rcl_map.svh are compiled first; bound to the top. */
`timescale 1ns/1ps
`include "rcl_map.svh"
module rcl_ref_clock_in_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic reg_wr_en,
    input wire logic [`RCL_REG_W-1:0] reg_addr,
    input wire rcl_pkg::rcl_reg_t reg_wr_data,
    input wire logic [`RCL_REG_W-1:0] reg_rd_data,
    // far side
    input wire logic ref_clock_in,
    input wire logic rate_tick,
    input wire logic lock_lost,
    // loop controls
    input wire logic lock_to_reference_mode,
    input wire rcl_pkg::rcl_range_t ref_range,
    input wire rcl_pkg::rcl_ratio_t ref_ratio_field,
    input wire logic acq_restart
);
    import rcl_pkg::*;
    logic [7:0] acq_ff;
    logic lock_lost_ff;
    wire wr_mode = reg_wr_en && reg_addr == `RCL_ADDR_MODE_CTRL;
    wire wr_acq = reg_wr_en && reg_addr == `RCL_ADDR_ACQ_CTRL;
    // shadow of the acquisition register: edges are judged against the stored value
    wire trig = (wr_mode && reg_wr_data[`RCL_MODE_LOCK_REF_BIT] && !lock_to_reference_mode)
        || (wr_acq && acq_ff[`RCL_ACQ_RESTART_BIT] && !reg_wr_data[`RCL_ACQ_RESTART_BIT])
        || (lock_to_reference_mode && lock_lost && !lock_lost_ff);
    always_ff @(posedge clk) begin
        acq_ff <= reset ? 8'h00 : (wr_acq ? reg_wr_data : acq_ff);
        lock_lost_ff <= reset ? 1'b0 : lock_lost;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    mode_bit_a: assert property (wr_mode |=> lock_to_reference_mode == $past(reg_wr_data[0]))
        else $error("lock mode does not follow the written bit");
    cfg_fields_a: assert property (wr_mode |=> {ref_range, ref_ratio_field} == $past(reg_wr_data[7:2]))
        else $error("range or ratio does not follow the write");
    cfg_hold_a: assert property (!wr_mode |=> $stable({lock_to_reference_mode, ref_range, ref_ratio_field}))
        else $error("lock settings moved without a write");
    lock_en_rise_a: assert property (wr_mode && reg_wr_data[0] && !lock_to_reference_mode |=> acq_restart)
        else $error("no restart on lock enable rising");
    acq_bit_a: assert property (wr_acq && acq_ff[5] && !reg_wr_data[5] |=> acq_restart)
        else $error("no restart on restart bit falling");
    relock_loss_a: assert property (lock_to_reference_mode && $rose(lock_lost) |=> acq_restart)
        else $error("no reacquire after lock loss");
    restart_cause_a: assert property (acq_restart |-> $past(trig))
        else $error("restart pulse without a cause");
    result_top_a: assert property ($past(reg_addr) == 8'h03 |-> reg_rd_data[7] == 1'b0)
        else $error("result high byte bit 7 set");
    done_clear_a: assert property (wr_acq && acq_ff[3] && !reg_wr_data[3] ##1 (reg_addr == 8'h02)[*4]
        |-> reg_rd_data[2] == 1'b0)
        else $error("done not cleared by measure restart");
    cover property (acq_restart);
    cover property (lock_to_reference_mode && $rose(lock_lost));
    cover property ($past(reg_addr) == 8'h02 && reg_rd_data[2]);
endmodule
bind rcl_ref_clock_in_ctrl rcl_ref_clock_in_checker chk (.clk(clk), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .ref_clock_in(ref_clock_in),
    .rate_tick(rate_tick), .lock_lost(lock_lost), .lock_to_reference_mode(lock_to_reference_mode),
    .ref_range(ref_range), .ref_ratio_field(ref_ratio_field), .acq_restart(acq_restart));

// ### tb/testbench.sv
/* self-checking bench of the reference clock control block.
   assumes rcl_pkg, rcl_map.svh, the design and the far side model. */
`timescale 1ns/1ps
`include "rcl_map.svh"
module testbench;
    import rcl_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    rcl_reg_t reg_wr_data = 8'h00;
    logic lock_lost = 1'b0;
    logic [7:0] reg_rd_data, v;
    logic ref_clock_in, rate_tick, lock_to_reference_mode, acq_restart;
    rcl_range_t ref_range;
    rcl_ratio_t ref_ratio_field;
    logic [22:0] res;
    logic [3:0] ratios [4] = '{4'h0, 4'h1, 4'h5, 4'h8};
    int n_mismatch = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    rcl_ref_clock_in_ctrl dut (.clk(clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .ref_clock_in(ref_clock_in), .rate_tick(rate_tick),
        .lock_lost(lock_lost), .lock_to_reference_mode(lock_to_reference_mode), .ref_range(ref_range),
        .ref_ratio_field(ref_ratio_field), .acq_restart(acq_restart));
    rcl_far_side far (.clk(clk), .reset(reset), .ref_clock_in(ref_clock_in), .rate_tick(rate_tick));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 q = reg_rd_data;
    endtask
    // called at the taking edge; the pulse stands only until the next edge
    task automatic pulse_is(input logic exp);
        #1 chk(acq_restart, exp);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        foreach (ratios[i]) begin
            rd(8'(i), v);
            chk(v, 8'h00);
            rd(8'(i + 3), v);
            chk(v, 8'h00);
        end
        $display("reset test done");
    endtask
    task automatic t_mode();
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {i[3:2], ratios[i[1:0]], 2'b01};
            wr(8'h00, 8'h00);
            wr(8'h00, d);
            pulse_is(1'b1);
            chk({ref_range, ref_ratio_field, lock_to_reference_mode}, {d[7:2], 1'b1});
            wr(8'h00, d);
            pulse_is(1'b0);
            rd(8'h00, v);
            chk(v, d);
        end
        $display("mode test done");
    endtask
    task automatic t_restart();
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h20);
        pulse_is(1'b0);
        wr(8'h01, 8'h00);
        pulse_is(1'b1);
        @(posedge clk);
        lock_lost <= 1'b1;
        @(posedge clk);
        pulse_is(1'b1);
        @(posedge clk);
        lock_lost <= 1'b0;
        // leave reference mode before measuring: both enables together are not allowed
        wr(8'h00, 8'h02);
        wr(8'h01, 8'h08);
        wr(8'h01, 8'h00);
        pulse_is(1'b0);
        @(posedge clk);
        lock_lost <= 1'b1;
        @(posedge clk);
        pulse_is(1'b0);
        @(posedge clk);
        lock_lost <= 1'b0;
        $display("restart test done");
    endtask
    task automatic t_meas();
        int k;
        // range 00 with a reference at clk/4 keeps the gate near 65536 cycles
        wr(8'h01, 8'h08);
        wr(8'h01, 8'h00);
        reg_addr <= 8'h02;
        repeat (3) @(posedge clk);
        #1 chk(reg_rd_data[2], 1'b0);
        for (k = 0; k < 70000 && reg_rd_data[2] !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(reg_rd_data[2], 1'b1);
        rd(8'h03, v);
        chk(v[7], 1'b0);
        res[22:16] = v[6:0];
        rd(8'h04, v);
        res[15:8] = v;
        rd(8'h05, v);
        res[7:0] = v;
        // ticks at half the reference give 2^13 over a 2^14 edge gate, one count of slack
        chk(res >= 23'h001FFF && res <= 23'h002001, 1'b1);
        wr(8'h01, 8'h08);
        wr(8'h01, 8'h00);
        reg_addr <= 8'h02;
        repeat (3) @(posedge clk);
        #1 chk(reg_rd_data[2], 1'b0);
        wr(8'h00, 8'h00);
        $display("measure test done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_mode();
        t_restart();
        t_meas();
        give_verdict();
    end
endmodule
